// ==== include/sdio_pkg.sv ====
// Package with constants, switch and state types for the step drive I/O control block.
package sdio_pkg;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int RAMP_TIME_MS = 275;
    localparam int INIT_TIME_MS = 325;
    localparam int RAMP_CYCLES = RAMP_TIME_MS * (CLK_HZ / 1000);
    localparam int INIT_CYCLES = INIT_TIME_MS * (CLK_HZ / 1000);
    localparam int SELFTEST_RPM = 60;
    localparam int SELFTEST_STEPS_PER_REV = 50_000;
    localparam int SELFTEST_STEP_CYCLES = (CLK_HZ / SELFTEST_STEPS_PER_REV) * 60 / SELFTEST_RPM;
    localparam int MAJOR_FAULTS = 7;
    localparam int CURRENT_W = 6;
    localparam int POS_W = 32;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_POSITION = 8'h08;
    localparam logic [7:0] OFS_INT_STAT = 8'h0C;
    localparam logic [7:0] OFS_INT_MASK = 8'h10;
    localparam int CTRL_SOFT_DISABLE_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [3:0] INT_MASK_RESET = 4'h0;
    localparam int IRQ_FAULT_BIT = 0;
    localparam int IRQ_INIT_DONE_BIT = 1;
    localparam int IRQ_DISABLE_BIT = 2;
    localparam int IRQ_RAMP_DONE_BIT = 3;
    localparam int STATUS_STATE_POS = 0;
    localparam int STATUS_SWITCH_POS = 4;
    localparam int STATUS_FAULT_POS = 16;
    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic dual_pulse_line_format;
        logic self_test;
        logic [CURRENT_W-1:0] current_setting;
    } sdio_switch_type;

    typedef enum logic [2:0] {
        ST_RESET,
        ST_INIT,
        ST_RUN,
        ST_DISABLED,
        ST_RAMP,
        ST_FAULT
    } sdio_state_type;
endpackage

// ==== rtl/sdio_sync.sv ====
// Two-stage synchroniser for a group of asynchronous level inputs.
`timescale 1ns/100ps
module sdio_sync #(
    parameter int WIDTH = 11
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    // The first stage feeds only the second stage.
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                meta_r[i] <= 1'b0;
                sync_out[i] <= 1'b0;
            end else begin
                meta_r[i] <= async_in[i]; // RULE14
                sync_out[i] <= meta_r[i]; // RULE14
            end
        end
    end
endmodule // sdio_sync

// ==== rtl/sdio_ramp.sv ====
// Current ramp generator that brings winding current from zero up to its setting.
`timescale 1ns/100ps
module sdio_ramp
    import sdio_pkg::*;
#(
    parameter int RAMP_CYCLES_P = RAMP_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic start,
    input wire logic active,
    input wire logic [CURRENT_W-1:0] target,
    output logic [CURRENT_W-1:0] level,
    output logic done
);
    // One increment per interval, so a full-scale ramp ends inside the limit.
    localparam int INTERVAL = RAMP_CYCLES_P / (1 << CURRENT_W);

    logic [31:0] tick_r;
    logic busy_r;
    wire logic tick_end = (tick_r == 32'(INTERVAL - 1));
    wire logic at_target = (level == target);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_r <= 32'h0000_0000;
            busy_r <= 1'b0;
            level <= '0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                tick_r <= 32'h0000_0000;
                busy_r <= 1'b1;
                level <= '0;
            end else if (!active) begin
                busy_r <= 1'b0;
                level <= '0;
            end else if (busy_r && at_target) begin
                busy_r <= 1'b0;
                done <= 1'b1;
            end else if (busy_r) begin
                tick_r <= tick_end ? 32'h0000_0000 : tick_r + 32'h0000_0001;
                if (tick_end) begin
                    level <= level + CURRENT_W'(1); // RULE3
                end
            end
        end
    end
endmodule // sdio_ramp

// ==== rtl/sdio_top.sv ====
// Step drive indexer I/O control: pulse inputs, disable, reset, fault output, self test.
//
// How it works
// RULE1 - Self-test steps the motor counter-clockwise at 60 RPM, 50,000 steps per turn.
// RULE2 - While disabled, both phases get zero current.
// RULE3 - On disable release, current ramps back to its setting within 275 ms.
// RULE4 - Fault indication holds while disabled and through the following ramp.
// RULE5 - Step pulses are ignored while disabled; position stays unchanged.
// RULE6 - After disable, drive resumes at the held microstep position.
// RULE7 - While reset is asserted, motor power is off and fault is shown.
// RULE8 - Initialisation starts on reset release and ends within 325 ms.
// RULE9 - Reset reruns self check and relatches switches; disable does neither.
// RULE10 - Fault output conducts only when fully operational.
// RULE11 - Any of seven major faults turns the fault output off.
// RULE12 - Exactly one step per rising edge on a pulse input.
// RULE13 - A switch selects dual pulse lines or step plus direction.
// RULE14 - Pulse, disable and reset inputs pass a two-stage synchroniser.
//
// Design decisions made here: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
module sdio_top
    import sdio_pkg::*;
#(
    parameter int RAMP_CYCLES_P = RAMP_CYCLES,
    parameter int INIT_CYCLES_P = INIT_CYCLES,
    parameter int SELFTEST_STEP_CYCLES_P = SELFTEST_STEP_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq,
    input wire logic step_or_clockwise_pulse,
    input wire logic direction_or_counterclockwise_pulse,
    input wire logic drive_disable,
    input wire logic drive_reset,
    input wire logic [MAJOR_FAULTS-1:0] major_fault,
    input wire sdio_pkg::sdio_switch_type switch_settings,
    output logic fault_output_conduct,
    output logic motor_power_en,
    output logic [CURRENT_W-1:0] winding_current_a,
    output logic [CURRENT_W-1:0] winding_current_b,
    output logic [POS_W-1:0] microstep_position
);
    import sdio_pkg::*;

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (RAMP_CYCLES_P < (1 << CURRENT_W) * 2) begin : g_bad_ramp
        $error("RAMP_CYCLES_P too small for the ramp resolution.");
    end
    if (INIT_CYCLES_P < 2) begin : g_bad_init
        $error("INIT_CYCLES_P must be at least 2.");
    end
    if (SELFTEST_STEP_CYCLES_P < 2) begin : g_bad_selftest
        $error("SELFTEST_STEP_CYCLES_P must be at least 2.");
    end

    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------
    localparam int SYNC_W = 4 + MAJOR_FAULTS;
    logic [SYNC_W-1:0] sync_out;

    sdio_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in({major_fault, drive_reset, drive_disable,
                   direction_or_counterclockwise_pulse, step_or_clockwise_pulse}),
        .sync_out(sync_out)
    );

    wire logic pulse0_s = sync_out[0];
    wire logic pulse1_s = sync_out[1];
    wire logic disable_s = sync_out[2];
    wire logic reset_s = sync_out[3];
    wire logic [MAJOR_FAULTS-1:0] fault_s = sync_out[SYNC_W-1:4];

    // ------------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------------
    sdio_state_type state_r;
    sdio_state_type state_nxt;
    sdio_switch_type switches_r;
    logic [31:0] init_cnt_r;
    logic [31:0] selftest_cnt_r;
    logic pulse0_d_r;
    logic pulse1_d_r;
    logic [31:0] ctrl_r;
    logic [3:0] int_stat_r;
    logic [3:0] int_mask_r;
    logic [7:0] wr_addr_r;
    logic wr_pend_r;
    logic [CURRENT_W-1:0] ramp_level;
    logic ramp_done;

    // ------------------------------------------------------------------
    // Drive state machine
    // ------------------------------------------------------------------
    wire logic any_fault = |fault_s; // RULE11
    wire logic dis_eff = disable_s | ctrl_r[CTRL_SOFT_DISABLE_BIT];
    wire logic init_end = (init_cnt_r == 32'(INIT_CYCLES_P - 1));

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_RESET: begin
                if (!reset_s) begin
                    state_nxt = ST_INIT; // RULE8
                end
            end
            ST_INIT: begin
                if (init_end) begin
                    if (any_fault) begin
                        state_nxt = ST_FAULT; // RULE9
                    end else if (dis_eff) begin
                        state_nxt = ST_DISABLED;
                    end else begin
                        state_nxt = ST_RUN; // RULE8
                    end
                end
            end
            ST_RUN: begin
                if (any_fault) begin
                    state_nxt = ST_FAULT;
                end else if (dis_eff) begin
                    state_nxt = ST_DISABLED;
                end
            end
            ST_DISABLED: begin
                if (any_fault) begin
                    state_nxt = ST_FAULT;
                end else if (!dis_eff) begin
                    state_nxt = ST_RAMP; // RULE3
                end
            end
            ST_RAMP: begin
                if (any_fault) begin
                    state_nxt = ST_FAULT;
                end else if (dis_eff) begin
                    state_nxt = ST_DISABLED;
                end else if (ramp_done) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_FAULT;
            end
        endcase
        if (reset_s) begin
            state_nxt = ST_RESET; // RULE7
        end
    end

    // A power-up is treated as a reset release, so the drive starts initialising.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= ST_INIT;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            init_cnt_r <= 32'h0000_0000;
        end else if (state_r != ST_INIT) begin
            init_cnt_r <= 32'h0000_0000;
        end else if (!init_end) begin
            init_cnt_r <= init_cnt_r + 32'h0000_0001; // RULE8
        end
    end

    // Switches are sampled only during initialisation; a disable never touches them.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            switches_r <= '0;
        end else if (state_r == ST_INIT) begin
            switches_r <= switch_settings; // RULE9
        end
    end

    // ------------------------------------------------------------------
    // Current ramp
    // ------------------------------------------------------------------
    wire logic ramp_start = (state_r == ST_DISABLED) && (state_nxt == ST_RAMP);

    sdio_ramp #(
        .RAMP_CYCLES_P(RAMP_CYCLES_P)
    ) u_ramp (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(ramp_start),
        .active(state_nxt == ST_RAMP),
        .target(switches_r.current_setting), // RULE3
        .level(ramp_level),
        .done(ramp_done)
    );

    // ------------------------------------------------------------------
    // Step pulse decoding
    // ------------------------------------------------------------------
    wire logic rise0 = pulse0_s & ~pulse0_d_r; // RULE12
    wire logic rise1 = pulse1_s & ~pulse1_d_r; // RULE12
    wire logic accept = (state_r == ST_RUN); // RULE5
    wire logic selftest_on = switches_r.self_test;
    wire logic selftest_tick = (selftest_cnt_r == 32'(SELFTEST_STEP_CYCLES_P - 1));
    // In dual-line format the two lines count up and down; otherwise line 1 is direction.
    wire logic cw_step = selftest_on ? 1'b0 :
        (switches_r.dual_pulse_line_format ? rise0 : (rise0 & ~pulse1_s)); // RULE13
    wire logic ccw_step = selftest_on ? selftest_tick : // RULE1
        (switches_r.dual_pulse_line_format ? rise1 : (rise0 & pulse1_s)); // RULE13
    wire logic [POS_W-1:0] pos_nxt = microstep_position
        + POS_W'(accept & cw_step) - POS_W'(accept & ccw_step);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pulse0_d_r <= 1'b0;
            pulse1_d_r <= 1'b0;
        end else begin
            pulse0_d_r <= pulse0_s;
            pulse1_d_r <= pulse1_s;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            selftest_cnt_r <= 32'h0000_0000;
        end else if (!selftest_on || !accept || selftest_tick) begin
            selftest_cnt_r <= 32'h0000_0000;
        end else begin
            selftest_cnt_r <= selftest_cnt_r + 32'h0000_0001; // RULE1
        end
    end

    // The position is kept across a disable so the winding phase is restored.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            microstep_position <= '0;
        end else if (state_r == ST_INIT) begin
            microstep_position <= '0;
        end else begin
            microstep_position <= pos_nxt; // RULE6
        end
    end

    // ------------------------------------------------------------------
    // Drive outputs
    // ------------------------------------------------------------------
    wire logic powered_nxt = (state_nxt == ST_RUN) || (state_nxt == ST_RAMP);
    wire logic [CURRENT_W-1:0] current_nxt =
        (state_nxt == ST_RUN) ? switches_r.current_setting :
        (state_nxt == ST_RAMP) ? ramp_level : '0; // RULE2

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_output_conduct <= 1'b0;
            motor_power_en <= 1'b0;
            winding_current_a <= '0;
            winding_current_b <= '0;
        end else begin
            fault_output_conduct <= (state_nxt == ST_RUN); // RULE4 RULE10
            motor_power_en <= powered_nxt; // RULE7
            winding_current_a <= current_nxt; // RULE2
            winding_current_b <= current_nxt; // RULE2
        end
    end

    // ------------------------------------------------------------------
    // Interrupt events
    // ------------------------------------------------------------------
    logic [3:0] events;
    assign events[IRQ_FAULT_BIT] = (state_nxt == ST_FAULT) && (state_r != ST_FAULT);
    assign events[IRQ_INIT_DONE_BIT] = (state_r == ST_INIT) && (state_nxt != ST_INIT);
    assign events[IRQ_DISABLE_BIT] = (state_nxt == ST_DISABLED) && (state_r != ST_DISABLED);
    assign events[IRQ_RAMP_DONE_BIT] = (state_r == ST_RAMP) && (state_nxt == ST_RUN);

    // ------------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------------
    wire logic addr_phase = hsel & htrans[1] & hready;
    wire logic [7:0] addr_lo = haddr[7:0];
    wire logic wr_ctrl = wr_pend_r && (wr_addr_r == OFS_CTRL);
    wire logic wr_int_stat = wr_pend_r && (wr_addr_r == OFS_INT_STAT);
    wire logic wr_int_mask = wr_pend_r && (wr_addr_r == OFS_INT_MASK);
    wire logic [3:0] stat_clear = wr_int_stat ? hwdata[3:0] : 4'h0;
    wire logic [3:0] int_stat_nxt = (int_stat_r & ~stat_clear) | events;

    logic [31:0] status_word;
    assign status_word = {9'h000, fault_s, 4'h0, switches_r, 1'b0, state_r};

    logic [31:0] rd_mux;
    always_comb begin
        if (addr_lo == OFS_CTRL) begin
            rd_mux = ctrl_r;
        end else if (addr_lo == OFS_STATUS) begin
            rd_mux = status_word;
        end else if (addr_lo == OFS_POSITION) begin
            rd_mux = microstep_position;
        end else if (addr_lo == OFS_INT_STAT) begin
            rd_mux = {28'h000_0000, int_stat_r};
        end else if (addr_lo == OFS_INT_MASK) begin
            rd_mux = {28'h000_0000, int_mask_r};
        end else begin
            rd_mux = 32'h0000_0000;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata <= 32'h0000_0000;
        end else begin
            wr_pend_r <= addr_phase & hwrite;
            wr_addr_r <= addr_lo;
            if (addr_phase && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    // Zero wait states and an OKAY answer always; there is nothing to refuse.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= CTRL_RESET;
            int_mask_r <= INT_MASK_RESET;
            int_stat_r <= 4'h0;
            irq <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= {31'h0000_0000, hwdata[CTRL_SOFT_DISABLE_BIT]};
            end
            if (wr_int_mask) begin
                int_mask_r <= hwdata[3:0];
            end
            int_stat_r <= int_stat_nxt;
            irq <= |(int_stat_nxt & int_mask_r);
        end
    end

    logic unused_ok;
    assign unused_ok = ^{haddr[31:8], hsize, hwdata[31:4]};
endmodule // sdio_top

// ==== verification/sdio_top_properties.sv ====
// Concurrent checks on the ports of the step drive I/O control block.
`timescale 1ns/100ps
module sdio_top_properties
    import sdio_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic drive_disable,
    input wire logic drive_reset,
    input wire logic [MAJOR_FAULTS-1:0] major_fault,
    input wire logic fault_output_conduct,
    input wire logic motor_power_en,
    input wire logic [CURRENT_W-1:0] winding_current_a,
    input wire logic [CURRENT_W-1:0] winding_current_b,
    input wire logic [POS_W-1:0] microstep_position,
    input wire logic hreadyout,
    input wire logic hresp
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Five cycles of input cover the synchroniser and the output register.
    a_reset_pin_off: assert property (
        drive_reset [*5] |-> !motor_power_en && !fault_output_conduct)
        else $error("Power or ok in reset.");
    a_disable_zero_current: assert property (
        drive_disable [*5] |-> winding_current_a == '0 && winding_current_b == '0)
        else $error("Current while disabled.");
    a_disable_no_ok: assert property (
        drive_disable [*5] |-> !fault_output_conduct)
        else $error("Ok shown while disabled.");
    a_fault_no_ok: assert property (
        (|major_fault) [*5] |-> !fault_output_conduct)
        else $error("Ok with a major fault.");
    a_disable_pos_hold: assert property (
        drive_disable [*5] |=> $stable(microstep_position))
        else $error("Position moved while disabled.");
    a_ramp_fault_hold: assert property (
        $fell(drive_disable) |-> !fault_output_conduct [*8])
        else $error("Ok early in the ramp.");
    a_ramp_time_bound: assert property (
        $fell(drive_disable) && major_fault == '0 |-> ##[1:300] fault_output_conduct)
        else $error("Ramp too slow.");
    a_init_time_bound: assert property (
        $fell(drive_reset) && major_fault == '0 && !drive_disable
        |-> ##[1:40] fault_output_conduct)
        else $error("Initialisation too slow.");
    a_power_off_current: assert property (
        !motor_power_en |-> winding_current_a == '0 && winding_current_b == '0)
        else $error("Current with power off.");
    a_bus_always_okay: assert property (
        hreadyout && !hresp)
        else $error("Bus not ready or not okay.");
    c_ramp_seen: cover property ($fell(drive_disable));
    c_reset_seen: cover property ($fell(drive_reset));
    c_step_seen: cover property ($changed(microstep_position));
endmodule // sdio_top_properties

bind sdio_top sdio_top_properties u_props (.hclk(hclk), .hresetn(hresetn),
    .drive_disable(drive_disable), .drive_reset(drive_reset), .major_fault(major_fault),
    .fault_output_conduct(fault_output_conduct), .motor_power_en(motor_power_en),
    .winding_current_a(winding_current_a), .winding_current_b(winding_current_b),
    .microstep_position(microstep_position), .hreadyout(hreadyout), .hresp(hresp));

// ==== verification/sdio_indexer_model.sv ====
// Behavioural indexer that produces step pulses in either input format.
`timescale 1ns/100ps
module sdio_indexer_model (
    input wire logic hclk,
    output logic step_line,
    output logic dir_line
);
    initial begin
        step_line = 1'b0;
        dir_line = 1'b0;
    end
    // Pulses stay high and low for 4 clocks, exactly the 200 ns minimum.
    task automatic send(input logic ccw, input logic dual);
        @(posedge hclk);
        if (dual) begin
            if (ccw) dir_line <= 1'b1;
            else step_line <= 1'b1;
        end else begin
            dir_line <= ccw;
            repeat (10) @(posedge hclk);
            step_line <= 1'b1;
        end
        repeat (4) @(posedge hclk);
        step_line <= 1'b0;
        if (dual) dir_line <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask
endmodule // sdio_indexer_model

// ==== verification/tb_top.sv ====
// Self-checking testbench for the step drive I/O control block.
`timescale 1ns/100ps
module tb_top;
    import sdio_pkg::*;
    logic hclk, hreadyout, hresp, irq, ok, pwr, step_line, dir_line, hready;
    logic hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, drive_disable = 1'b0, drive_reset = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic [MAJOR_FAULTS-1:0] major_fault = '0;
    sdio_switch_type sw = '{1'b1, 1'b0, 6'h2A};
    logic [CURRENT_W-1:0] cur_a, cur_b;
    logic [POS_W-1:0] pos, pos0;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    assign hready = hreadyout;
    sdio_top #(.RAMP_CYCLES_P(256), .INIT_CYCLES_P(20), .SELFTEST_STEP_CYCLES_P(8)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .step_or_clockwise_pulse(step_line),
        .direction_or_counterclockwise_pulse(dir_line), .drive_disable(drive_disable),
        .drive_reset(drive_reset), .major_fault(major_fault), .switch_settings(sw),
        .fault_output_conduct(ok), .motor_power_en(pwr), .winding_current_a(cur_a),
        .winding_current_b(cur_b), .microstep_position(pos));
    sdio_indexer_model idx (.hclk(hclk), .step_line(step_line), .dir_line(dir_line));
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task test_done;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // The whole run needs about 1000 cycles, so 20000 only trips on a hang.
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            $display("[FAIL] %0t timeout", $time);
            test_done;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask
    task ahb_xfer(input logic [31:0] a, input logic wr, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
    endtask
    task rd_chk(input logic [31:0] a, input logic [31:0] exp, input string what);
        ahb_xfer(a, 1'b0, 32'h0000_0000);
        chk(hrdata, exp, what);
    endtask
    task wait_ok(input int lim);
        for (int n = 0; n < lim && ok !== 1'b1; n++) @(posedge hclk);
        chk(32'(ok), 32'h1, "drive ready");
    endtask
    task reset_pin;
        @(posedge hclk);
        drive_reset <= 1'b1;
        repeat (6) @(posedge hclk);
        chk({30'h0, pwr, ok}, 32'h0, "reset state");
        drive_reset <= 1'b0;
        wait_ok(60);
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        wait_ok(60);
        chk(32'(cur_a), 32'h2A, "full current after init");
        repeat (3) idx.send(1'b0, 1'b1);
        idx.send(1'b1, 1'b1);
        repeat (4) @(posedge hclk);
        chk(pos, 32'h2, "dual line count");
        rd_chk(32'(OFS_POSITION), 32'h2, "position register");
        drive_disable <= 1'b1;
        repeat (6) @(posedge hclk);
        chk(32'({cur_a, cur_b}), 32'h0, "disabled current");
        chk({30'h0, pwr, ok}, 32'h0, "disabled outputs");
        rd_chk(32'(OFS_STATUS), 32'h0000_0AA3, "disabled status");
        idx.send(1'b0, 1'b1);
        repeat (4) @(posedge hclk);
        chk(pos, 32'h2, "step while disabled");
        sw.current_setting <= 6'h15;
        drive_disable <= 1'b0;
        repeat (10) @(posedge hclk);
        chk(32'(ok), 32'h0, "ok during ramp");
        wait_ok(400);
        chk(32'(cur_a), 32'h2A, "no relatch on disable");
        chk(pos, 32'h2, "phase kept");
        rd_chk(32'(OFS_INT_STAT), 32'h0000_000E, "event flags");
        chk(32'(irq), 32'h0, "irq masked");
        ahb_xfer(32'(OFS_INT_MASK), 1'b1, 32'h0000_0004);
        repeat (2) @(posedge hclk);
        chk(32'(irq), 32'h1, "irq unmasked");
        ahb_xfer(32'(OFS_INT_STAT), 1'b1, 32'h0000_0004);
        repeat (2) @(posedge hclk);
        chk(32'(irq), 32'h0, "irq cleared");
        rd_chk(32'(OFS_INT_STAT), 32'h0000_000A, "flags after clear");
        rd_chk(32'(OFS_INT_MASK), 32'h0000_0004, "mask readback");
        rd_chk(32'h0000_0040, 32'h0000_0000, "unmapped read");
        ahb_xfer(32'(OFS_CTRL), 1'b1, 32'h0000_0001);
        repeat (3) @(posedge hclk);
        chk(32'(pwr), 32'h0, "soft disable");
        ahb_xfer(32'(OFS_CTRL), 1'b1, 32'h0000_0000);
        wait_ok(400);
        sw.dual_pulse_line_format <= 1'b0;
        reset_pin;
        chk(32'(cur_a), 32'h15, "relatch on reset");
        chk(pos, 32'h0, "position after reset");
        repeat (2) idx.send(1'b0, 1'b0);
        idx.send(1'b1, 1'b0);
        repeat (4) @(posedge hclk);
        chk(pos, 32'h1, "step and direction count");
        sw.self_test <= 1'b1;
        reset_pin;
        pos0 = pos;
        repeat (80) @(posedge hclk);
        chk(pos - pos0, 32'hFFFF_FFF6, "self test steps");
        sw.self_test <= 1'b0;
        for (int i = 0; i < MAJOR_FAULTS; i++) begin
            major_fault <= 7'h1 << i;
            repeat (6) @(posedge hclk);
            chk(32'(ok), 32'h0, "major fault");
            major_fault <= '0;
            reset_pin;
        end
        test_done;
    end
endmodule // tb_top
